// [hdl/dwpbc_pkg.sv]
/*
  Constants and types for the DRAM wait, precharge and bank mapping block.
  Assumes a single 125 MHz system clock; the DRAM CLK is derived inside the block.
*/
package dwpbc_pkg;

  // ----------------------------------------------------------------
  // DRAM CLK generation
  // ----------------------------------------------------------------
  localparam logic [1:0] CLK_HALF_CYC = 2'h2;
  localparam logic [1:0] CLK_DIV_LAST = 2'h3;

  // ----------------------------------------------------------------
  // Precharge and refresh low time, in positive DRAM CLK edges
  // ----------------------------------------------------------------
  localparam logic [2:0] PRE_T_0 = 3'h2;
  localparam logic [2:0] PRE_T_1 = 3'h2;
  localparam logic [2:0] PRE_T_2 = 3'h3;
  localparam logic [2:0] PRE_T_3 = 3'h3;
  localparam logic [3:0] LOW_T_0 = 4'h2;
  localparam logic [3:0] LOW_T_1 = 4'h3;
  localparam logic [3:0] LOW_T_2 = 4'h3;
  localparam logic [3:0] LOW_T_3 = 4'h4;
  localparam logic [2:0] PRE_CNT_RST = 3'h7;
  localparam logic [2:0] PRE_CNT_FIRST = 3'h1;

  // ----------------------------------------------------------------
  // Wait extension
  // ----------------------------------------------------------------
  localparam logic [3:0] EXT_ONE = 4'h1;
  localparam logic [3:0] EXT_TWO = 4'h2;

  // ----------------------------------------------------------------
  // Array configuration codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CFG_ONE_SCRUB  = 3'h0;
  localparam logic [2:0] CFG_TWO_SCRUB  = 3'h1;
  localparam logic [2:0] CFG_FOUR_SCRUB = 3'h2;
  localparam logic [2:0] CFG_ONE        = 3'h3;
  localparam logic [2:0] CFG_TWO        = 3'h5;
  localparam logic [2:0] CFG_BYTE       = 3'h6;
  localparam logic [2:0] CFG_FOUR       = 3'h7;

  // ----------------------------------------------------------------
  // Refresh address counter
  // ----------------------------------------------------------------
  localparam int REF_W     = 24;
  localparam int TEST_LO_W = 13;
  localparam int TEST_HI_W = 11;

  // Synchroniser idle value: {refresh, extend_n, bank[1:0], casEn_n[3:0], req_n, strobe_n}.
  localparam logic [9:0] PIN_IDLE = 10'h13F;

  typedef enum logic [1:0] {ST_IDLE, ST_PRECHG, ST_ACTIVE, ST_REFRESH} dwpbc_state_t;

endpackage

// [hdl/dwpbc_top.sv]
/*
  DRAM wait, precharge and RAS/CAS bank mapping logic.
  Assumes asynchronous host and refresh pins, static programming bits, and a
  DRAM CLK equal to sys_clk divided by four, driven out on dramClkOut.
*/
`timescale 1ns/1ps
`default_nettype none
module dwpbc_top
  import dwpbc_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Host access and refresh pins
  input  wire logic       addrStrobeIn_n,
  input  wire logic       accessRequestIn_n,
  input  wire logic [3:0] casEnableIn_n,
  input  wire logic [1:0] bankSelectIn,
  input  wire logic       waitExtendIn_n,
  input  wire logic       refreshRequestIn,
  // Programming bits
  input  wire logic [2:0] arrayConfigBits,
  input  wire logic [1:0] prechargeLowTimeBits,
  input  wire logic       waitExtendCountBit,
  input  wire logic       ackStyleBit,
  input  wire logic [1:0] ackDelayEdges,
  input  wire logic       ackDelayHalf,
  input  wire logic       sequencedRefresh,
  input  wire logic       scrubEnable,
  // DRAM and host outputs
  output logic [3:0]      rasOut_n,
  output logic [3:0]      casOut_n,
  output logic            waitOut_n,
  output logic            transferAckOut_n,
  output logic            dramClkOut,
  output logic [23:0]     refreshAddr,
  output logic            refreshBusy
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [9:0] pinMeta_q;
  logic [9:0] pinSync_q;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pinMeta_q <= PIN_IDLE;
      pinSync_q <= PIN_IDLE;
    end
    else
    begin
      pinMeta_q <= {refreshRequestIn, waitExtendIn_n, bankSelectIn, casEnableIn_n,
                    accessRequestIn_n, addrStrobeIn_n};
      pinSync_q <= pinMeta_q;
    end
  end

  logic       strobe;
  logic       request;
  logic [3:0] casEn;
  logic [1:0] bank;
  logic       extend;
  logic       refreshReq;
  assign strobe     = ~pinSync_q[0];
  assign request    = ~pinSync_q[1];
  assign casEn      = ~pinSync_q[5:2];
  assign bank       = pinSync_q[7:6];
  assign extend     = ~pinSync_q[8];
  assign refreshReq = pinSync_q[9];

  // ----------------------------------------------------------------
  // Programming decode
  // ----------------------------------------------------------------
  logic [2:0] preT;
  logic [3:0] lowT;
  logic [3:0] extT;
  logic       pipeMode;
  logic       scrubOk;
  logic       testMode;
  logic [3:0] newRas;
  logic [3:0] newCas;
  logic [3:0] scrubCas;
  logic [7:0] scrubMap;

  always_comb
  begin
    case (prechargeLowTimeBits)
      2'h0:    begin preT = PRE_T_0; lowT = LOW_T_0; end
      2'h1:    begin preT = PRE_T_1; lowT = LOW_T_1; end
      2'h2:    begin preT = PRE_T_2; lowT = LOW_T_2; end
      default: begin preT = PRE_T_3; lowT = LOW_T_3; end
    endcase
  end

  // Extra edges are taken from the live pin when a delay starts.
  assign extT     = extend ? (waitExtendCountBit ? EXT_TWO : EXT_ONE) : 4'h0;
  assign pipeMode = (arrayConfigBits == CFG_FOUR) || (arrayConfigBits == CFG_FOUR_SCRUB) ||
                    (arrayConfigBits == CFG_TWO) || (arrayConfigBits == CFG_TWO_SCRUB);
  assign scrubOk  = (arrayConfigBits == CFG_ONE_SCRUB) || (arrayConfigBits == CFG_TWO_SCRUB) ||
                    (arrayConfigBits == CFG_FOUR_SCRUB);
  assign testMode = sequencedRefresh && scrubEnable;

  function automatic logic [7:0] bankMap(input logic [2:0] cfg, input logic [1:0] b);
    logic [3:0] one;
    one = 4'h1 << b;
    case (cfg)
      CFG_BYTE:                 bankMap = {4'hF, one};
      CFG_FOUR, CFG_FOUR_SCRUB: bankMap = {one, one};
      CFG_TWO, CFG_TWO_SCRUB:   bankMap = b[0] ? {4'hC, 4'hC} : {4'h3, 4'h3};
      default:                  bankMap = {4'hF, 4'hF};
    endcase
  endfunction

  assign {newCas, newRas} = bankMap(arrayConfigBits, bank);

  function automatic logic [3:0] refRas(input logic [3:0] n, input logic stag,
                                        input logic [3:0] low);
    logic [3:0] st;
    refRas = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      st = stag ? 4'(i) : 4'h0;
      refRas[i] = (n >= st) && (n < st + low);
    end
  endfunction

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  dwpbc_state_t state_q, state_d;
  logic [1:0]  divCnt_q, divCnt_d;
  logic        clkLevel_q, clkLevel_d;
  logic [3:0]  rasOutN_q, rasOutN_d;
  logic [3:0]  casOutN_q, casOutN_d;
  logic        waitOutN_q, waitOutN_d;
  logic        ackOutN_q, ackOutN_d;
  logic [3:0]  curMask_q, curMask_d;
  logic [3:0]  oldMask_q, oldMask_d;
  logic [3:0]  casMask_q, casMask_d;
  logic        strobePrev_q;
  logic        ackRun_q, ackRun_d;
  logic        ackHalf_q, ackHalf_d;
  logic        burstIdle_q, burstIdle_d;
  logic [3:0]  ackCnt_q, ackCnt_d;
  logic [3:0]  ackTarget_q, ackTarget_d;
  logic [3:0]  refCnt_q, refCnt_d;
  logic [23:0] refreshAddr_q, refreshAddr_d;
  logic        refDone;
  logic        ackStart;
  logic [2:0]  prechg_q [4];
  logic [2:0]  prechg_d [4];
  logic [3:0]  preDone;
  logic        riseEn;
  logic        fallEn;

  // Scrub CAS follows the refresh bank bits through the same mapping as an access.
  assign scrubMap = bankMap(arrayConfigBits, refreshAddr_q[23:22]);
  assign scrubCas = scrubMap[7:4];
  assign riseEn = (divCnt_q == 2'h0);
  assign fallEn = (divCnt_q == CLK_HALF_CYC);
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      preDone[i] = (prechg_q[i] >= preT);
  end

  always_comb
  begin
    state_d = state_q;
    divCnt_d = (divCnt_q == CLK_DIV_LAST) ? 2'h0 : divCnt_q + 2'h1;
    clkLevel_d = riseEn ? 1'b1 : (fallEn ? 1'b0 : clkLevel_q);
    rasOutN_d = rasOutN_q;
    casOutN_d = casOutN_q;
    waitOutN_d = waitOutN_q;
    ackOutN_d = ackOutN_q;
    curMask_d = curMask_q;
    oldMask_d = oldMask_q;
    casMask_d = casMask_q;
    ackRun_d = ackRun_q;
    ackHalf_d = ackHalf_q;
    burstIdle_d = burstIdle_q;
    ackCnt_d = ackCnt_q;
    ackTarget_d = ackTarget_q;
    refCnt_d = refCnt_q;
    refreshAddr_d = refreshAddr_q;
    refDone = 1'b0;
    ackStart = 1'b0;
    prechg_d = prechg_q;
    if (riseEn)
    begin
      if (ackRun_q)
        ackCnt_d = ackCnt_q + 4'h1;
      case (state_q)
        ST_IDLE:
        begin
          if (refreshReq && (&preDone))
          begin
            state_d = ST_REFRESH;
            refCnt_d = 4'h0;
            rasOutN_d = ~refRas(4'h0, sequencedRefresh, lowT);
          end
          else if (strobe && request)
          begin
            curMask_d = newRas;
            casMask_d = newCas;
            waitOutN_d = ackStyleBit;
            ackOutN_d = 1'b1;
            state_d = ST_PRECHG;
            if ((newRas & ~preDone) == 4'h0)
            begin
              rasOutN_d = rasOutN_q & ~newRas;
              state_d = ST_ACTIVE;
              ackStart = 1'b1;
            end
          end
        end
        ST_PRECHG:
        begin
          if (!request)
          begin
            state_d = ST_IDLE;
            waitOutN_d = 1'b1;
          end
          else if ((curMask_q & ~preDone) == 4'h0)
          begin
            rasOutN_d = rasOutN_q & ~curMask_q;
            state_d = ST_ACTIVE;
            ackStart = 1'b1;
          end
        end
        ST_ACTIVE:
        begin
          if (!request)
          begin
            casOutN_d = 4'hF;
            waitOutN_d = 1'b1;
            ackOutN_d = 1'b1;
            ackRun_d = 1'b0;
            ackHalf_d = 1'b0;
            if (oldMask_q != 4'h0)
            begin
              // The older pipelined access ends; the newer one keeps its RAS.
              rasOutN_d = rasOutN_q | oldMask_q;
              oldMask_d = 4'h0;
            end
            else
            begin
              rasOutN_d = rasOutN_q | curMask_q;
              state_d = ST_IDLE;
            end
          end
          else if (pipeMode && strobe && !strobePrev_q && (oldMask_q == 4'h0) &&
                   ((newRas & curMask_q) == 4'h0) && ((newRas & ~preDone) == 4'h0))
          begin
            // A bank that owns its own lines can open while another is still open.
            rasOutN_d = rasOutN_q & ~newRas;
            casOutN_d = 4'hF;
            oldMask_d = curMask_q;
            curMask_d = newRas;
            casMask_d = newCas;
            waitOutN_d = ackStyleBit;
            ackOutN_d = 1'b1;
            ackStart = 1'b1;
          end
          else
          begin
            casOutN_d = ~(casMask_q & casEn);
            if (casEn == 4'h0 && !ackRun_q && !ackHalf_q)
            begin
              // Enables released: withdraw the answer until the next column.
              burstIdle_d = 1'b1;
              ackOutN_d = 1'b1;
              waitOutN_d = ackStyleBit;
            end
            else if (casEn != 4'h0 && burstIdle_q)
            begin
              burstIdle_d = 1'b0;
              ackStart = 1'b1;
            end
          end
        end
        ST_REFRESH:
        begin
          refCnt_d = refCnt_q + 4'h1;
          rasOutN_d = ~refRas(refCnt_d, sequencedRefresh, lowT);
          casOutN_d = 4'hF;
          if (!sequencedRefresh && scrubOk && scrubEnable && refCnt_d < lowT)
            casOutN_d = ~scrubCas;
          if (refCnt_d == (sequencedRefresh ? 4'h3 : 4'h0) + lowT)
          begin
            state_d = ST_IDLE;
            refDone = 1'b1;
            if (testMode)
              refreshAddr_d = {refreshAddr_q[23:13] + 11'h001, refreshAddr_q[12:0] + 13'h0001};
            else
              refreshAddr_d = refreshAddr_q + 24'h000001;
          end
        end
        default: state_d = ST_IDLE;
      endcase
      if (ackStart)
      begin
        ackRun_d = 1'b1;
        // A burst pause left over from the previous access must not restart this count.
        burstIdle_d = 1'b0;
        ackHalf_d = 1'b0;
        ackCnt_d = 4'h0;
        ackTarget_d = {2'h0, ackDelayEdges} + extT;
      end
      if (ackRun_d && ackCnt_d >= ackTarget_d)
      begin
        ackRun_d = 1'b0;
        if (ackDelayHalf)
          ackHalf_d = 1'b1;
        else if (ackStyleBit)
          ackOutN_d = 1'b0;
        else
          waitOutN_d = 1'b1;
      end
      for (int i = 0; i < 4; i++)
      begin
        if (refDone || (!rasOutN_q[i] && rasOutN_d[i]))
          prechg_d[i] = PRE_CNT_FIRST;
        else if (rasOutN_q[i] && prechg_q[i] < preT)
          prechg_d[i] = prechg_q[i] + 3'h1;
      end
    end
    else if (fallEn && ackHalf_q)
    begin
      // The trailing half edge comes only after every positive edge.
      ackHalf_d = 1'b0;
      if (ackStyleBit)
        ackOutN_d = 1'b0;
      else
        waitOutN_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      divCnt_q <= 2'h0;
      clkLevel_q <= 1'b0;
      rasOutN_q <= 4'hF;
      casOutN_q <= 4'hF;
      waitOutN_q <= 1'b1;
      ackOutN_q <= 1'b1;
      curMask_q <= 4'h0;
      oldMask_q <= 4'h0;
      casMask_q <= 4'h0;
      strobePrev_q <= 1'b0;
      ackRun_q <= 1'b0;
      ackHalf_q <= 1'b0;
      burstIdle_q <= 1'b0;
      ackCnt_q <= 4'h0;
      ackTarget_q <= 4'h0;
      refCnt_q <= 4'h0;
      refreshAddr_q <= 24'h000000;
      refreshBusy <= 1'b0;
      for (int i = 0; i < 4; i++)
        prechg_q[i] <= PRE_CNT_RST;
    end
    else
    begin
      state_q <= state_d;
      divCnt_q <= divCnt_d;
      clkLevel_q <= clkLevel_d;
      rasOutN_q <= rasOutN_d;
      casOutN_q <= casOutN_d;
      waitOutN_q <= waitOutN_d;
      ackOutN_q <= ackOutN_d;
      curMask_q <= curMask_d;
      oldMask_q <= oldMask_d;
      casMask_q <= casMask_d;
      strobePrev_q <= riseEn ? strobe : strobePrev_q;
      ackRun_q <= ackRun_d;
      ackHalf_q <= ackHalf_d;
      burstIdle_q <= burstIdle_d;
      ackCnt_q <= ackCnt_d;
      ackTarget_q <= ackTarget_d;
      refCnt_q <= refCnt_d;
      refreshAddr_q <= refreshAddr_d;
      refreshBusy <= (state_d == ST_REFRESH);
      prechg_q <= prechg_d;
    end
  end

  assign rasOut_n         = rasOutN_q;
  assign casOut_n         = casOutN_q;
  assign waitOut_n        = waitOutN_q;
  assign transferAckOut_n = ackOutN_q;
  assign dramClkOut       = clkLevel_q;
  assign refreshAddr      = refreshAddr_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_start_ext;
    riseEn && ackStart && extend;
  endsequence

  a_ras_prechg: assert property (
    !(|(~rasOutN_q & $past(rasOutN_q) & ~$past(preDone))))
    else $error("RAS asserted before its precharge count elapsed");
  a_ext_latch: assert property (s_start_ext |=>
    ackTarget_q == {2'h0, $past(ackDelayEdges)} + (waitExtendCountBit ? EXT_TWO : EXT_ONE))
    else $error("wait extension not added to the delay");
  a_half_last: assert property (
    $fell(ackOutN_q) && ackDelayHalf |-> $past(fallEn) && $past(ackHalf_q))
    else $error("half level honoured before positive edges");
  a_burst_drop: assert property (
    riseEn && state_q == ST_ACTIVE && request && !ackOutN_q && casEn == 4'h0 &&
    !$rose(strobe) |=> ackOutN_q)
    else $error("acknowledge not withdrawn between burst columns");
  a_byte_single: assert property (
    state_q == ST_ACTIVE && arrayConfigBits == CFG_BYTE |-> $onehot(~rasOutN_q))
    else $error("byte mode access did not drive exactly one RAS");
  a_one_bank: assert property (
    state_q == ST_ACTIVE && (arrayConfigBits == CFG_ONE || arrayConfigBits == CFG_ONE_SCRUB)
    |-> rasOutN_q == 4'h0)
    else $error("single bank access did not drive all RAS");
  a_refresh_entry: assert property ($rose(refreshBusy) |-> $past(&preDone, 2))
    else $error("refresh began before precharge elapsed");
  a_test_split: assert property (
    refDone && riseEn && testMode |=>
    refreshAddr_q[12:0] == $past(refreshAddr_q[12:0]) + 13'h0001 &&
    refreshAddr_q[23:13] == $past(refreshAddr_q[23:13]) + 11'h001)
    else $error("test mode refresh counters did not both advance");
  a_wait_start: assert property (
    riseEn && state_q == ST_IDLE && !refreshReq && strobe && request && !ackStyleBit
    |=> !waitOutN_q ##1 !waitOutN_q)
    else $error("wait output not asserted at access start");

endmodule
`default_nettype wire

// [testbench/dwpbc_host_model.sv]
/*
  Host bus model that drives the block's access pins for one access per go pulse.
  Assumes go is raised for one cycle, and only after done was seen.
*/
`timescale 1ns/1ps
`default_nettype none
module dwpbc_host_model
  import dwpbc_pkg::*;
(
  // Bench control
  input  wire logic        sys_clk,
  input  wire logic        go,
  input  wire logic [11:0] goAddr,
  input  wire logic [3:0]  goEn_n,
  input  wire logic        goExt_n,
  input  wire logic        ackStyleBit,
  output logic             done,
  // Block pins
  input  wire logic [3:0]  rasOut_n,
  input  wire logic        waitOut_n,
  input  wire logic        transferAckOut_n,
  output logic             addrStrobeIn_n,
  output logic             accessRequestIn_n,
  output logic [3:0]       casEnableIn_n,
  output logic [1:0]       bankSelectIn,
  output logic             waitExtendIn_n
);
  int n;
  initial
  begin
    {done, bankSelectIn} = 3'h0;
    {addrStrobeIn_n, accessRequestIn_n, casEnableIn_n, waitExtendIn_n} = 7'h7F;
    forever
    begin
      @(posedge sys_clk);
      if (go)
      begin
        @(negedge sys_clk);
        bankSelectIn = goAddr[11:10];
        casEnableIn_n = goEn_n;
        waitExtendIn_n = goExt_n;
        {addrStrobeIn_n, accessRequestIn_n} = 2'h0;
        // The cycle stays open until the block answers, so RAS time is covered.
        for (n = 0; n < 400; n++)
        begin
          @(negedge sys_clk);
          if (ackStyleBit ? !transferAckOut_n : rasOut_n != 4'hF && waitOut_n) break;
        end
        @(negedge sys_clk);
        {addrStrobeIn_n, accessRequestIn_n, casEnableIn_n, waitExtendIn_n} = 7'h7F;
        // Released bank lines show the inverse, so a stale value cannot pass.
        bankSelectIn = ~bankSelectIn;
        for (n = 0; n < 400 && rasOut_n != 4'hF; n++) @(negedge sys_clk);
        repeat (4) @(negedge sys_clk);
        done = 1'b1;
        @(negedge sys_clk);
        done = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/dwpbc_tb_top.sv]
/*
  Self-checking bench for the DRAM wait, precharge and bank mapping block.
  Assumes the host model drives the access pins and the bench all the rest.
*/
`timescale 1ns/1ps
`default_nettype none
module dwpbc_tb_top;
  import dwpbc_pkg::*;
  typedef struct {logic [3:0] ras; logic [3:0] cas; int lat;} dwpbc_exp_t;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        go = 1'b0;
  logic        goExt_n, refreshRequestIn, waitExtendCountBit, ackStyleBit, ackDelayHalf;
  logic        sequencedRefresh, scrubEnable, done, addrStrobeIn_n, accessRequestIn_n;
  logic        waitExtendIn_n, waitOut_n, transferAckOut_n, refreshBusy;
  logic [11:0] goAddr;
  logic [3:0]  goEn_n, casEnableIn_n, rasOut_n, casOut_n;
  logic [2:0]  arrayConfigBits;
  logic [1:0]  bankSelectIn, prechargeLowTimeBits, ackDelayEdges;
  logic [23:0] refreshAddr;
  logic [2:0]  preTab [4] = '{PRE_T_0, PRE_T_1, PRE_T_2, PRE_T_3};
  logic [3:0]  lowTab [4] = '{LOW_T_0, LOW_T_1, LOW_T_2, LOW_T_3};
  dwpbc_exp_t  expQ [$];
  int          n_errors = 0, comparisons = 0, cyc = 0, rasAt = 0, lowAt = 0;
  int          riseAt [4] = '{-99, -99, -99, -99};
  logic [3:0]  lastRas = 4'hF;
  logic        lastAck = 1'b1, lastWait = 1'b1, inRefresh = 1'b0;

  always #4 sys_clk = ~sys_clk;

  dwpbc_top dwpbc_top_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .addrStrobeIn_n(addrStrobeIn_n),
    .accessRequestIn_n(accessRequestIn_n), .casEnableIn_n(casEnableIn_n),
    .bankSelectIn(bankSelectIn), .waitExtendIn_n(waitExtendIn_n),
    .refreshRequestIn(refreshRequestIn), .arrayConfigBits(arrayConfigBits),
    .prechargeLowTimeBits(prechargeLowTimeBits), .waitExtendCountBit(waitExtendCountBit),
    .ackStyleBit(ackStyleBit), .ackDelayEdges(ackDelayEdges), .ackDelayHalf(ackDelayHalf),
    .sequencedRefresh(sequencedRefresh), .scrubEnable(scrubEnable), .rasOut_n(rasOut_n),
    .casOut_n(casOut_n), .waitOut_n(waitOut_n), .transferAckOut_n(transferAckOut_n),
    .dramClkOut(), .refreshAddr(refreshAddr), .refreshBusy(refreshBusy));

  dwpbc_host_model dwpbc_host_model_inst (
    .sys_clk(sys_clk), .go(go), .goAddr(goAddr), .goEn_n(goEn_n), .goExt_n(goExt_n),
    .ackStyleBit(ackStyleBit), .done(done), .rasOut_n(rasOut_n), .waitOut_n(waitOut_n),
    .transferAckOut_n(transferAckOut_n), .addrStrobeIn_n(addrStrobeIn_n),
    .accessRequestIn_n(accessRequestIn_n), .casEnableIn_n(casEnableIn_n),
    .bankSelectIn(bankSelectIn), .waitExtendIn_n(waitExtendIn_n));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Returns {RAS mask, CAS mask}; two-bank tests keep both bank bits equal.
  function automatic logic [7:0] masks(input logic [2:0] c, input logic [1:0] b);
    logic [3:0] one;
    logic [3:0] two;
    one = 4'h1 << b;
    two = b[0] ? 4'hC : 4'h3;
    if (c == CFG_BYTE) return {one, 4'hF};
    if (c == CFG_FOUR || c == CFG_FOUR_SCRUB) return {one, one};
    if (c == CFG_TWO || c == CFG_TWO_SCRUB) return {two, two};
    return 8'hFF;
  endfunction

  task automatic access(input logic [11:0] addr);
    logic [7:0] m;
    dwpbc_exp_t e;
    m = masks(arrayConfigBits, addr[11:10]);
    @(negedge sys_clk);
    goEn_n = 4'($urandom);
    goExt_n = 1'($urandom);
    goAddr = addr;
    e.ras = ~m[7:4];
    e.cas = ~(m[3:0] & ~goEn_n);
    e.lat = 4 * (ackDelayEdges + (goExt_n ? 0 : waitExtendCountBit + 1)) + 2 * ackDelayHalf;
    expQ.push_back(e);
    go = 1'b1;
    @(negedge sys_clk);
    go = 1'b0;
    wait (done === 1'b1);
  endtask

  always @(posedge sys_clk)
  begin
    dwpbc_exp_t e;
    int         gap;
    cyc++;
    if (!sys_rst)
    begin
      if (lastRas == 4'hF && rasOut_n != 4'hF) rasAt = cyc;
      for (int i = 0; i < 4; i++)
      begin
        if (!lastRas[i] && rasOut_n[i]) riseAt[i] = cyc;
        gap = cyc - riseAt[i];
        // The negating rise enable is 1T, so the gap spans the full count of DRAM clocks.
        if (lastRas[i] && !rasOut_n[i])
          check("precharge gap", gap >= 4 * preTab[prechargeLowTimeBits], 1);
      end
      if (inRefresh && lastRas[0] && !rasOut_n[0]) lowAt = cyc;
      if (inRefresh && !lastRas[0] && rasOut_n[0])
        check("refresh low time", cyc - lowAt, 4 * lowTab[prechargeLowTimeBits]);
      if ((ackStyleBit ? lastAck && !transferAckOut_n : !lastWait && waitOut_n && rasOut_n != 4'hF)
          && expQ.size() > 0)
      begin
        e = expQ.pop_front();
        check("ras lines", rasOut_n, e.ras);
        check("cas lines", casOut_n, e.cas);
        check("answer delay", cyc - rasAt, e.lat);
      end
    end
    lastRas = rasOut_n;
    lastAck = transferAckOut_n;
    lastWait = waitOut_n;
  end

  initial
  begin
    #200000;
    n_errors++;
    complete_run();
  end

  initial
  begin
    logic [1:0]  b;
    logic [23:0] a;
    {goExt_n, goAddr, goEn_n, refreshRequestIn, sequencedRefresh, scrubEnable} = '0;
    {arrayConfigBits, prechargeLowTimeBits, ackDelayEdges} = 7'h01;
    {waitExtendCountBit, ackStyleBit, ackDelayHalf} = 3'h0;
    void'($urandom(98));
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'b0;
    for (int c = 0; c < 24; c++)
    begin
      @(negedge sys_clk);
      arrayConfigBits = 3'(c);
      {prechargeLowTimeBits, waitExtendCountBit, ackStyleBit, ackDelayHalf} = 5'($urandom);
      ackDelayEdges = 2'($urandom % 3 + 1);
      b = 2'($urandom);
      if (arrayConfigBits inside {CFG_TWO, CFG_TWO_SCRUB}) b = {2{b[0]}};
      // The second access hits the same bank as soon as done is seen, yet arrives only once its precharge count has elapsed.
      access({b, 10'h0});
      access({b, 10'h0});
    end
    for (int k = 0; k < 16; k++)
    begin
      @(negedge sys_clk);
      {prechargeLowTimeBits, sequencedRefresh, scrubEnable} = 4'(k);
      arrayConfigBits = CFG_FOUR_SCRUB;
      a = refreshAddr;
      inRefresh = 1'b1;
      refreshRequestIn = 1'b1;
      wait (refreshBusy === 1'b1);
      @(negedge sys_clk);
      refreshRequestIn = 1'b0;
      // One DRAM clock into an all-RAS refresh, the scrub CAS of refresh bank 0 is low.
      repeat (4) @(negedge sys_clk);
      check("scrub cas", casOut_n, (scrubEnable && !sequencedRefresh) ? 4'hE : 4'hF);
      while (refreshBusy !== 1'b0) @(negedge sys_clk);
      repeat (8) @(negedge sys_clk);
      inRefresh = 1'b0;
      if (sequencedRefresh && scrubEnable)
        check("test mode address", refreshAddr, {a[23:13] + 11'h1, a[12:0] + 13'h1});
      else
        check("refresh address", refreshAddr, a + 24'h1);
      access(12'h0);
    end
    repeat (20) @(negedge sys_clk);
    check("pending answers", expQ.size(), 0);
    complete_run();
  end
endmodule
`default_nettype wire
